// ---- byte_skid_buffer.sv ----
// small shift-register fifo between the serial engine and the array writer
`timescale 1ns/1ps
`default_nettype none
module byte_skid_buffer #(
   parameter int unsigned WIDTH = 25,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic             in_valid_in,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  in_ready_out,
   output logic                  out_valid_out,
   output logic      [WIDTH-1:0] out_data_out,
   input  wire logic             out_ready_in
);
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;

   if (DEPTH < 2 || WIDTH < 1) begin : g_bad
      $error("byte_skid_buffer needs DEPTH >= 2 and WIDTH >= 1");
   end

   assign push = in_valid_in & in_ready_out;
   assign pop  = out_valid_out & out_ready_in;
   assign out_data_out = mem[0];

   // ***************************************************************
   // storage: head always sits in entry 0 so the output is a flop
   // ***************************************************************
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_in) begin
         if (!rst_b_in) begin
            mem[i] <= '0;
         end else if (pop) begin
            if (push && count == CW'(i + 1)) begin
               mem[i] <= in_data_in;
            end else if (i + 1 < DEPTH) begin
               mem[i] <= mem[(i + 1) % DEPTH];
            end
         end else if (push && count == CW'(i)) begin
            mem[i] <= in_data_in;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         count         <= '0;
         out_valid_out <= 1'b0;
         in_ready_out  <= 1'b0;
      end else begin
         if (push && !pop) begin
            count         <= count + CW'(1);
            out_valid_out <= 1'b1;
            in_ready_out  <= (count + CW'(1)) != CW'(DEPTH);
         end else if (pop && !push) begin
            count         <= count - CW'(1);
            out_valid_out <= count != CW'(1);
            in_ready_out  <= 1'b1;
         end else begin
            out_valid_out <= count != '0;
            in_ready_out  <= count != CW'(DEPTH);
         end
      end
   end
endmodule
`default_nettype wire

// ---- eeprom_i2c_checker.sv ----
// port-level assertions for the eeprom two-wire slave front end
`timescale 1ns/1ps
`default_nettype none
module eeprom_i2c_checker #(
   parameter int unsigned WRITE_CYCLES = 400
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic scl_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic fixed_select_pin_in,
   input wire logic write_protect_in,
   input wire logic write_commit_out,
   input wire logic write_discard_out,
   input wire logic busy_out
);
   int unsigned low_cnt;
   int unsigned busy_len;
   // pin-level count, so the sync delay only adds margin
   always_ff @(posedge clk_in) begin
      if (!rst_b_in || scl_in) low_cnt <= 0;
      else low_cnt <= low_cnt + 1;
   end
   always_ff @(posedge clk_in) begin
      if (!rst_b_in || !busy_out) busy_len <= 0;
      else busy_len <= busy_len + 1;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence commit_s; write_commit_out; endsequence
   sequence busy_run_s; busy_out [*8]; endsequence
   oe_hold_a: assert property ($changed(sda_oe_out) |-> !scl_in && low_cnt >= 12)
      else $error("data output moved too soon after clock fall");
   oe_stable_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
      else $error("data output moved while clock high");
   ack_low_a: assert property (sda_oe_out |-> !sda_out)
      else $error("driven data level not low");
   fixed_pin_a: assert property ($rose(sda_oe_out) |-> fixed_select_pin_in)
      else $error("answer while fixed select low");
   busy_start_a: assert property (commit_s |-> ##[0:1] busy_run_s)
      else $error("busy not raised by commit");
   busy_len_a: assert property ($fell(busy_out) |-> busy_len == WRITE_CYCLES)
      else $error("busy length wrong");
   wp_commit_a: assert property (commit_s |-> !write_protect_in && !write_discard_out)
      else $error("commit while protected");
   discard_idle_a: assert property (write_discard_out |-> !busy_out ##1 !busy_out)
      else $error("busy after discard");
endmodule
bind eeprom_i2c_slave_addressing eeprom_i2c_checker #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
   .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .sda_out(sda_out),
   .sda_oe_out(sda_oe_out), .fixed_select_pin_in(fixed_select_pin_in),
   .write_protect_in(write_protect_in), .write_commit_out(write_commit_out),
   .write_discard_out(write_discard_out), .busy_out(busy_out));
`default_nettype wire

// ---- eeprom_i2c_slave_addressing.sv ----
// two-wire slave front end of a serial eeprom: conditions, control byte, address, ack
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_slave_cfg.svh"

// Functional notes
// - programming cycle keeps device busy, at most 5 ms
// - hold driven data 300 ns after clock fall
// - select only when both chip-select bits match
// - fixed select pin low means no response
// - data changes only while clock is low
// - write-protect high inhibits writes, reads unaffected
// - data fall with clock high is start
// - data rise with clock high is stop
// - one bit per clock, sampled while high
// - addressed receiver acknowledges each byte, ninth clock; a data byte that meets a full write buffer gets no ack here
// - no ack for busy cycle's own control byte
// - acknowledge holds data low through high phase
// - master nack ends read, device releases line
// - control byte: type, segment, selects, direction
// - segment bit becomes upper array address bit
// - direction bit one reads, zero writes
// - two address bytes follow, high byte first
// - ack control byte only on type and select
// - sequential reads wrap inside one segment
module eeprom_i2c_slave_addressing #(
   parameter int unsigned WRITE_CYCLES = `EE_WRITE_CYCLES,
   parameter int unsigned BUF_DEPTH    = `EE_BUF_DEPTH,
   parameter logic [3:0]  DEVICE_TYPE  = 4'h5 // arbitrary value
) (
   input  wire logic                           clk_in,
   input  wire logic                           rst_b_in,
   input  wire logic                           scl_in,
   input  wire logic                           sda_in,
   output logic                                sda_out,
   output logic                                sda_oe_out,
   input  wire logic                           chip_select_low_pin_in,
   input  wire logic                           chip_select_high_pin_in,
   input  wire logic                           fixed_select_pin_in,
   input  wire logic                           write_protect_in,
   output logic                                wr_valid_out,
   output logic      [`EE_ADDR_W-1:0]          wr_addr_out,
   output logic      [7:0]                     wr_data_out,
   input  wire logic                           wr_ready_in,
   output logic                                write_commit_out,
   output logic                                write_discard_out,
   output logic                                busy_out,
   output logic                                rd_req_out,
   output logic      [`EE_ADDR_W-1:0]          rd_addr_out,
   input  wire logic [7:0]                     rd_data_in,
   output eeprom_slave_pkg::link_state_t       link_state_out
);
   import eeprom_slave_pkg::*;

   localparam int unsigned HOLD_CYCLES = `EE_HOLD_CYCLES;
   localparam int unsigned BW = `EE_ADDR_W + 8;

   if (WRITE_CYCLES < 1 || HOLD_CYCLES < 1 || HOLD_CYCLES > 255) begin : g_bad
      $error("eeprom_i2c_slave_addressing: unusable timing parameters");
   end

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic                  scl_m, scl_s, scl_p;
   logic                  sda_m, sda_s, sda_p;
   logic [3:0]            pin_m, pin_s;
   logic                  scl_rise, scl_fall;
   logic                  start_cond, stop_cond;
   link_state_t           state;
   byte_kind_t            kind;
   logic [3:0]            bit_cnt;
   logic [7:0]            rx_byte;
   logic [7:0]            tx_byte;
   logic [7:0]            cur_ctrl;
   logic [7:0]            busy_ctrl;
   logic                  read_mode;
   logic                  master_ack;
   logic                  wr_pending;
   logic [`EE_ADDR_W-1:0] addr;
   logic                  byte_done;
   logic                  byte_ok;
   logic                  buf_push;
   logic                  buf_ready;
   logic [BW-1:0]         buf_out;
   logic                  next_rd_req;
   logic                  tx_load;
   logic [7:0]            hold_cnt;
   logic                  drive_low;
   logic [31:0]           wc_cnt;

   // ***************************************************************
   // decode helper
   // ***************************************************************
   function automatic logic ctrl_selects(input logic [7:0] b,
                                         input logic [3:0] pins);
      // pins: {wp, fixed, cs_hi, cs_lo}
      ctrl_selects = pins[2]
                     && b[`EE_CTRL_TYPE_MSB:`EE_CTRL_TYPE_LSB] == DEVICE_TYPE
                     && b[`EE_CTRL_CS_HI_BIT] == pins[1]
                     && b[`EE_CTRL_CS_LO_BIT] == pins[0];
   endfunction

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_p <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_m <= scl_in;
         scl_s <= scl_m;
         scl_p <= scl_s;
         sda_m <= sda_in;
         sda_s <= sda_m;
         sda_p <= sda_s;
      end
   end

   // straps and write-protect are static, but still crossed before use
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         pin_m <= 4'h0;
         pin_s <= 4'h0;
      end else begin
         pin_m <= {write_protect_in, fixed_select_pin_in,
                   chip_select_high_pin_in, chip_select_low_pin_in};
         pin_s <= pin_m;
      end
   end

   // ***************************************************************
   // bus conditions
   // ***************************************************************
   assign scl_rise   = scl_s & ~scl_p;
   assign scl_fall   = ~scl_s & scl_p;
   assign start_cond = scl_s & scl_p & sda_p & ~sda_s;
   assign stop_cond  = scl_s & scl_p & ~sda_p & sda_s;
   assign byte_done  = scl_fall && state == st_rx && bit_cnt == 4'h8;

   always_comb begin
      byte_ok = 1'b0;
      case (kind)
         bk_ctrl: begin
            byte_ok = ctrl_selects(rx_byte, pin_s)
                      && !(busy_out && rx_byte == busy_ctrl);
         end
         bk_addr_hi: byte_ok = 1'b1;
         bk_addr_lo: byte_ok = 1'b1;
         bk_data:    byte_ok = buf_ready;
         default:    byte_ok = 1'b0;
      endcase
   end

   assign buf_push = byte_done && kind == bk_data && byte_ok;

   // ***************************************************************
   // byte engine
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state      <= st_idle;
         kind       <= bk_ctrl;
         bit_cnt    <= 4'h0;
         rx_byte    <= `EE_BYTE_RESET;
         tx_byte    <= `EE_BYTE_RESET;
         cur_ctrl   <= `EE_BYTE_RESET;
         read_mode  <= 1'b0;
         master_ack <= 1'b0;
         wr_pending <= 1'b0;
         addr       <= `EE_ADDR_RESET;
      end else if (start_cond) begin
         state      <= st_rx;
         kind       <= bk_ctrl;
         bit_cnt    <= 4'h0;
         wr_pending <= 1'b0;
      end else if (stop_cond) begin
         state      <= st_idle;
         bit_cnt    <= 4'h0;
         wr_pending <= 1'b0;
      end else begin
         if (tx_load) begin
            tx_byte <= rd_data_in;
         end
         if (next_rd_req) begin
            // pointer stays inside its segment
            addr[`EE_SEG_ADDR_BIT-1:0] <= addr[`EE_SEG_ADDR_BIT-1:0] + 16'h0001;
         end
         case (state)
            st_rx: begin
               if (scl_rise && bit_cnt != 4'h8) begin
                  rx_byte <= {rx_byte[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  if (byte_ok) begin
                     state <= st_ack;
                     case (kind)
                        bk_ctrl: begin
                           cur_ctrl  <= rx_byte;
                           read_mode <= rx_byte[`EE_CTRL_RW_BIT];
                           addr[`EE_SEG_ADDR_BIT] <= rx_byte[`EE_CTRL_SEG_BIT];
                           kind      <= bk_addr_hi;
                        end
                        bk_addr_hi: begin
                           addr[15:8] <= rx_byte;
                           kind       <= bk_addr_lo;
                        end
                        bk_addr_lo: begin
                           addr[7:0] <= rx_byte;
                           kind      <= bk_data;
                        end
                        default: begin
                           // page roll-over: only the low bits advance
                           addr[`EE_PAGE_BITS-1:0] <= addr[`EE_PAGE_BITS-1:0] + 7'h01;
                           wr_pending <= 1'b1;
                        end
                     endcase
                  end else begin
                     state <= st_idle;
                  end
               end
            end
            st_ack: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  state   <= read_mode ? st_tx : st_rx;
               end
            end
            st_tx: begin
               if (scl_fall) begin
                  tx_byte <= {tx_byte[6:0], 1'b1};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h7) begin
                     state <= st_rack;
                  end
               end
            end
            st_rack: begin
               if (scl_rise) begin
                  master_ack <= ~sda_s;
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  state   <= master_ack ? st_tx : st_idle;
               end
            end
            default: begin
               bit_cnt <= 4'h0;
            end
         endcase
      end
   end

   // ***************************************************************
   // read requests toward the array
   // ***************************************************************
   always_comb begin
      next_rd_req = 1'b0;
      if (!start_cond && !stop_cond) begin
         if (byte_done && kind == bk_ctrl && byte_ok && rx_byte[`EE_CTRL_RW_BIT]) begin
            next_rd_req = 1'b1;
         end else if (state == st_rack && scl_rise && !sda_s) begin
            next_rd_req = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         rd_req_out  <= 1'b0;
         rd_addr_out <= `EE_ADDR_RESET;
         tx_load     <= 1'b0;
      end else begin
         rd_req_out <= next_rd_req;
         tx_load    <= rd_req_out;
         if (next_rd_req) begin
            // the segment bit of a fresh control byte is not in addr yet
            rd_addr_out <= (state == st_rx)
                           ? {rx_byte[`EE_CTRL_SEG_BIT], addr[`EE_SEG_ADDR_BIT-1:0]}
                           : addr;
         end
      end
   end

   // ***************************************************************
   // data line driver
   // ***************************************************************
   assign drive_low = (state == st_ack)
                      || (state == st_tx && !tx_byte[7]);

   // new levels wait out the hold window after each clock fall
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         hold_cnt   <= 8'h00;
         sda_oe_out <= 1'b0;
         sda_out    <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         if (scl_fall) begin
            hold_cnt <= 8'(HOLD_CYCLES);
         end else if (hold_cnt != 8'h00) begin
            hold_cnt <= hold_cnt - 8'h01;
         end
         if (hold_cnt == 8'h00 && !scl_s) begin
            sda_oe_out <= drive_low;
         end else if (state == st_idle || state == st_rx) begin
            sda_oe_out <= sda_oe_out & ~(start_cond | stop_cond);
         end
      end
   end

   // ***************************************************************
   // internal write cycle
   // ***************************************************************
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         write_commit_out  <= 1'b0;
         write_discard_out <= 1'b0;
         busy_out          <= 1'b0;
         busy_ctrl         <= `EE_BYTE_RESET;
         wc_cnt            <= 32'h0000_0000;
      end else begin
         write_commit_out  <= 1'b0;
         write_discard_out <= 1'b0;
         if (wr_pending && stop_cond && !pin_s[3]) begin
            write_commit_out <= 1'b1;
            busy_out         <= 1'b1;
            busy_ctrl        <= cur_ctrl;
            wc_cnt           <= WRITE_CYCLES - 1;
         end else begin
            if (wr_pending && (stop_cond || start_cond)) begin
               write_discard_out <= 1'b1;
            end
            if (wc_cnt != 32'h0000_0000) begin
               wc_cnt <= wc_cnt - 32'h0000_0001;
            end else begin
               busy_out <= 1'b0;
            end
         end
      end
   end

   // ***************************************************************
   // write data buffer
   // ***************************************************************
   // a full buffer withholds the ack, so no byte is ever dropped silently
   byte_skid_buffer #(
      .WIDTH (BW),
      .DEPTH (BUF_DEPTH)
   ) u_wbuf (
      .clk_in        (clk_in),
      .rst_b_in      (rst_b_in),
      .in_valid_in   (buf_push),
      .in_data_in    ({addr, rx_byte}),
      .in_ready_out  (buf_ready),
      .out_valid_out (wr_valid_out),
      .out_data_out  (buf_out),
      .out_ready_in  (wr_ready_in)
   );

   assign wr_addr_out    = buf_out[BW-1:8];
   assign wr_data_out    = buf_out[7:0];
   assign link_state_out = state;
endmodule
`default_nettype wire

// ---- eeprom_slave_cfg.svh ----
// constants of the serial eeprom slave front end: offsets, fields, resets, timing
`ifndef EEPROM_SLAVE_CFG_SVH
`define EEPROM_SLAVE_CFG_SVH

// ***************************************************************
// control byte fields
// ***************************************************************
`define EE_CTRL_RW_BIT       0
`define EE_CTRL_CS_LO_BIT    1
`define EE_CTRL_CS_HI_BIT    2
`define EE_CTRL_SEG_BIT      3
`define EE_CTRL_TYPE_LSB     4
`define EE_CTRL_TYPE_MSB     7

// ***************************************************************
// address layout and reset values
// ***************************************************************
`define EE_ADDR_W            17
`define EE_SEG_ADDR_BIT      16
`define EE_PAGE_BITS         7
`define EE_ADDR_RESET        17'h00000
`define EE_BYTE_RESET        8'h00

// ***************************************************************
// timing and write buffer depth
// ***************************************************************
`define EE_CLK_PERIOD_NS     25
`define EE_HOLD_NS           300
`define EE_HOLD_CYCLES       ((`EE_HOLD_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)
`define EE_WRITE_MAX_MS      5
`define EE_WRITE_TYP_MS      3
`define EE_WRITE_CYCLES      ((`EE_WRITE_TYP_MS * 1000000) / `EE_CLK_PERIOD_NS)
`define EE_BUF_DEPTH         2

`endif

// ---- eeprom_slave_pkg.sv ----
// types shared by the serial eeprom slave front end
package eeprom_slave_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_rx,
      st_ack,
      st_tx,
      st_rack
   } link_state_t;

   typedef enum logic [1:0] {
      bk_ctrl,
      bk_addr_hi,
      bk_addr_lo,
      bk_data
   } byte_kind_t;
endpackage

// ---- i2c_master_model.sv ----
// bus master model: drives the link clock and the pulled-up data wire
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model #(
   parameter int LOW_CLK  = 20,
   parameter int HIGH_CLK = 4
) (
   input  wire logic clk_in,
   input  wire logic dev_pull_in,
   output logic      scl_out,
   output logic      sda_out
);
   logic pull;
   // long low phase: the slave holds its data 300 ns past each fall
   assign sda_out = ~(pull | dev_pull_in);
   initial begin
      scl_out = 1'b1;
      pull = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_in);
   endtask
   task automatic bit_io(input logic b, output logic s);
      pull = ~b;
      tick(LOW_CLK);
      scl_out = 1'b1;
      tick(HIGH_CLK / 2);
      s = sda_out;
      tick(HIGH_CLK / 2);
      scl_out = 1'b0;
   endtask
   task automatic start();
      pull = 1'b0;
      tick(LOW_CLK);
      scl_out = 1'b1;
      tick(HIGH_CLK);
      pull = 1'b1;
      tick(HIGH_CLK);
      scl_out = 1'b0;
   endtask
   task automatic stop();
      pull = 1'b1;
      tick(LOW_CLK);
      scl_out = 1'b1;
      tick(HIGH_CLK);
      // no idle tail here: start() supplies the free time, and the caller
      // must see the commit or discard pulse that follows the stop
      pull = 1'b0;
   endtask
   task automatic send(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(d[i], s);
      bit_io(1'b1, s);
      ack = ~s;
   endtask
   task automatic recv(input logic last, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
      bit_io(last, s);
   endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the eeprom two-wire slave front end
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int WCYC = 400;
   localparam logic [3:0] DEV_TYPE = 4'hB; // arbitrary type code
   logic        clk_in, rst_b_in, scl, sda, oe, sda_dq, cs_lo, cs_hi, fixed, wp;
   logic        wr_valid, wr_ready, commit, discard, busy, rd_req, k;
   logic [16:0] wr_addr, rd_addr;
   logic [7:0]  wr_data, rd_data, d;
   logic [24:0] taken [$];
   eeprom_slave_pkg::link_state_t lst;
   int          cmp_count, fail_count, cycles;
   eeprom_i2c_slave_addressing #(.WRITE_CYCLES(WCYC), .DEVICE_TYPE(DEV_TYPE)) uut (
      .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_dq),
      .sda_oe_out(oe), .chip_select_low_pin_in(cs_lo), .chip_select_high_pin_in(cs_hi),
      .fixed_select_pin_in(fixed), .write_protect_in(wp), .wr_valid_out(wr_valid),
      .wr_addr_out(wr_addr), .wr_data_out(wr_data), .wr_ready_in(wr_ready),
      .write_commit_out(commit), .write_discard_out(discard), .busy_out(busy),
      .rd_req_out(rd_req), .rd_addr_out(rd_addr), .rd_data_in(rd_data), .link_state_out(lst));
   i2c_master_model m (.clk_in(clk_in), .dev_pull_in(oe), .scl_out(scl), .sda_out(sda));
   always #12.5 clk_in = ~clk_in;
   always @(posedge clk_in) if (wr_valid && wr_ready) taken.push_back({wr_addr, wr_data});
   // array stand-in: content is a fixed function of the address
   always @(negedge clk_in) if (rd_req) rd_data <= rd_addr[7:0] ^ 8'h5A;
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [7:0] cb(input logic s, input logic [1:0] c, input logic r);
      return {DEV_TYPE, s, c, r};
   endfunction
   task automatic ctl(input logic [7:0] c, input logic e);
      m.start();
      m.send(c, k);
      chk("control ack", e, k);
   endtask
   task automatic addr2(input logic [15:0] a);
      m.send(a[15:8], k);
      chk("addr hi ack", 1, k);
      m.send(a[7:0], k);
      chk("addr lo ack", 1, k);
   endtask
   task automatic wait_for(ref logic s, input logic v, input int lim);
      logic ok;
      ok = 0;
      repeat (lim) if (!ok) begin
         @(negedge clk_in);
         ok = (s === v);
      end
      chk("wait flag", 1, ok);
   endtask
   task automatic t_stall();
      logic [7:0] dat [3] = '{8'hA1, 8'hB2, 8'hC3};
      taken.delete();
      wr_ready = 0;
      ctl(cb(1, 2'b10, 0), 1);
      addr2(16'h127F);
      for (int i = 0; i < 3; i++) begin
         m.send(dat[i], k);
         chk("data ack", i < 2, k);
      end
      wr_ready = 1;
      repeat (4) @(negedge clk_in);
      chk("entries", 2, taken.size());
      chk("entry 0", {17'h1127F, 8'hA1}, taken[0]);
      chk("entry 1", {17'h11200, 8'hB2}, taken[1]);
      m.stop();
      repeat (WCYC + 20) @(negedge clk_in);
   endtask
   task automatic t_commit();
      taken.delete();
      ctl(cb(0, 2'b10, 0), 1);
      addr2(16'h0040);
      m.send(8'h3C, k);
      m.stop();
      wait_for(commit, 1, 20);
      chk("entry", {17'h00040, 8'h3C}, taken[0]);
      chk("busy", 1, busy);
      ctl(cb(0, 2'b10, 0), 0);
      m.stop();
      wait_for(busy, 0, WCYC);
      ctl(cb(0, 2'b10, 0), 1);
      m.stop();
   endtask
   task automatic t_refuse();
      for (int i = 0; i < 3; i++) begin
         fixed = (i != 2);
         ctl(cb(0, 2'b10, 0) ^ (i == 0 ? 8'h80 : i == 1 ? 8'h06 : 8'h00), 0);
         m.send(8'h00, k);
         chk("ignored byte", 0, k);
         m.stop();
      end
      fixed = 1;
   endtask
   task automatic t_protect();
      wp = 1;
      ctl(cb(1, 2'b10, 0), 1);
      addr2(16'h0100);
      m.send(8'h77, k);
      chk("protected data ack", 1, k);
      m.stop();
      wait_for(discard, 1, 20);
      chk("busy after discard", 0, busy);
      wp = 0;
   endtask
   task automatic t_read();
      ctl(cb(0, 2'b10, 0), 1);
      addr2(16'hFFFF);
      ctl(cb(0, 2'b10, 1), 1);
      m.recv(0, d);
      chk("read first", 8'hFF ^ 8'h5A, d);
      m.recv(1, d);
      chk("read wrap", 8'h00 ^ 8'h5A, d);
      repeat (16) @(negedge clk_in);
      chk("line released", 0, oe);
      chk("link state", eeprom_slave_pkg::st_idle, lst);
      m.stop();
   endtask
   initial begin
      {clk_in, rst_b_in, cs_lo, wp, rd_data} = '0;
      {cs_hi, fixed, wr_ready} = 3'b111;
      repeat (4) @(negedge clk_in);
      rst_b_in = 1;
      repeat (4) @(negedge clk_in);
      t_stall();
      $display("stall test done");
      t_commit();
      $display("commit test done");
      t_refuse();
      $display("refuse test done");
      t_protect();
      $display("protect test done");
      t_read();
      $display("read test done");
      close_out();
   end
endmodule
`default_nettype wire
